// ---- tpcm_pkg.sv ----
package tpcm_pkg;

    // ------------------------------------------------------------------
    // Register indices (printed offsets; byte address is index * 4)
    // ------------------------------------------------------------------
    localparam logic [11:0] IDX_CURVE_SEL    = 12'h332;
    localparam logic [11:0] IDX_CUR_LOW_PT   = 12'h339;
    localparam logic [11:0] IDX_CUR_PROP_LO  = 12'h33A;
    localparam logic [11:0] IDX_CUR_MID_PT   = 12'h33B;
    localparam logic [11:0] IDX_CUR_PROP_MID = 12'h33C;
    localparam logic [11:0] IDX_CUR_HIGH_PT  = 12'h33D;
    localparam logic [11:0] IDX_CUR_PROP_HI  = 12'h33E;
    localparam logic [11:0] IDX_VOL_LOW_PT   = 12'h33F;
    localparam logic [11:0] IDX_VOL_PROP_LO  = 12'h340;
    localparam logic [11:0] IDX_VOL_MID_PT   = 12'h341;
    localparam logic [11:0] IDX_VOL_PROP_MID = 12'h342;
    localparam logic [11:0] IDX_VOL_HIGH_PT  = 12'h343;
    localparam logic [11:0] IDX_VOL_PROP_HI  = 12'h344;
    localparam logic [11:0] IDX_INPUT_TYPE   = 12'h31C;
    localparam logic [11:0] IDX_MAX_FREQ     = 12'h100;
    localparam logic [11:0] IDX_STATUS       = 12'h350;
    localparam logic [11:0] IDX_CUR_LEVEL    = 12'h351;
    localparam logic [11:0] IDX_VOL_LEVEL    = 12'h352;

    localparam int          IDX_LSB          = 2;
    localparam int          IDX_W            = 12;

    // ------------------------------------------------------------------
    // Reset values, scaled by one hundred
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_CUR_LOW_PT   = 16'h0190; // 4.00 mA
    localparam logic [15:0] RST_CUR_PROP_LO  = 16'h0000; // 0.00 %
    localparam logic [15:0] RST_CUR_MID_PT   = 16'h04B0; // 12.00 mA
    localparam logic [15:0] RST_CUR_PROP_MID = 16'h1388; // 50.00 %
    localparam logic [15:0] RST_CUR_HIGH_PT  = 16'h07D0; // 20.00 mA
    localparam logic [15:0] RST_CUR_PROP_HI  = 16'h2710; // 100.00 %
    localparam logic [15:0] RST_VOL_LOW_PT   = 16'h0000; // 0.00 V
    localparam logic [15:0] RST_VOL_PROP_LO  = 16'h0000; // 0.00 %
    localparam logic [15:0] RST_VOL_MID_PT   = 16'h01F4; // 5.00 V
    localparam logic [15:0] RST_VOL_PROP_MID = 16'h1388; // 50.00 %
    localparam logic [15:0] RST_VOL_HIGH_PT  = 16'h03E8; // 10.00 V
    localparam logic [15:0] RST_VOL_PROP_HI  = 16'h2710; // 100.00 %
    localparam logic [15:0] RST_MAX_FREQ     = 16'h1770; // 60.00 Hz
    localparam logic [1:0]  RST_INPUT_TYPE   = 2'h0;

    // Full scale of a percentage, 100.00 %
    localparam logic [15:0] PCT_FULL         = 16'h2710;
    // Range limits of the input level readings
    localparam logic [15:0] CUR_MAX_20MA     = 16'h07D0;
    localparam logic [15:0] CUR_MIN_4MA      = 16'h0190;
    localparam logic [15:0] VOL_MAX_10V      = 16'h03E8;

    // Status bit positions
    localparam int          ST_CUR_BELOW     = 0;
    localparam int          ST_VOL_BELOW     = 1;
    localparam int          ST_CUR_ACTIVE    = 2;
    localparam int          ST_VOL_ACTIVE    = 3;
    localparam int          ST_REVERSE       = 4;

    typedef enum logic [1:0] {
        TPCM_CURVE_NORMAL  = 2'b00,
        TPCM_CURVE_VOLTAGE = 2'b01,
        TPCM_CURVE_CURRENT = 2'b10
    } tpcm_curve_type;

    typedef enum logic [1:0] {
        TPCM_IT_VOLT_0_10 = 2'b00,
        TPCM_IT_CUR_0_20  = 2'b01,
        TPCM_IT_CUR_4_20  = 2'b10
    } tpcm_itype_type;

endpackage : tpcm_pkg

// ---- tpcm_curve_mapper.sv ----
`timescale 1ns/1ps
// Summary of operation
// - With current input chosen, 100 percent output equals maximum frequency.
// - Interpolate linearly between bracketing points; proportions unordered.
// - Current output is zero while current is below the low point.
// - Just above the low point, current output is the low proportion.
// - Current points range 0-20 mA for type 1, 4-20 mA for type 2.
// - Current proportions are unsigned 0-100 percent, defaults 0, 50 and 100.
// - Voltage 100 percent equals maximum frequency; positive means forward.
// - Voltage output is zero while voltage is below the low point.
// - Just above the low point, voltage output is the low proportion.
// - Voltage points 0-10 V, defaults 0, 5 and 10 volts.
// - Voltage proportions signed -100 to 100 percent, defaults 0, 50, 100.
// - Curve selector: 0 normal, 1 voltage curve, 2 current curve.
// - Current low point sits at index 0339, default 4.00 mA.
module tpcm_curve_mapper
    import tpcm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        level_valid_i,
    input  wire logic [15:0] current_level_i,
    input  wire logic [15:0] voltage_level_i,
    output logic             cmd_valid_o,
    output logic             cmd_curve_o,
    output logic      [15:0] cmd_percent_o,
    output logic             cmd_reverse_o,
    output logic      [31:0] cmd_freq_o
);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [15:0]    pt_r [0:11];
    logic [1:0]     curve_sel_r;
    logic [1:0]     input_type_r;
    logic [15:0]    max_freq_r;
    logic [15:0]    cur_lvl_r;
    logic [15:0]    vol_lvl_r;
    logic [4:0]     status_r;
    logic [IDX_W-1:0] idx;
    logic           req;
    logic           wr_en;
    logic [15:0]    wdat;
    logic [3:0]     pt_sel;
    logic           pt_hit;

    localparam logic [15:0] PT_RST [0:11] = '{
        RST_CUR_LOW_PT, RST_CUR_PROP_LO, RST_CUR_MID_PT, RST_CUR_PROP_MID,
        RST_CUR_HIGH_PT, RST_CUR_PROP_HI, RST_VOL_LOW_PT, RST_VOL_PROP_LO,
        RST_VOL_MID_PT, RST_VOL_PROP_MID, RST_VOL_HIGH_PT, RST_VOL_PROP_HI
    };

    assign idx    = adr_i[IDX_LSB +: IDX_W];
    assign req    = cyc_i && stb_i && !ack_o;
    assign wr_en  = req && we_i;
    assign pt_hit = (idx >= IDX_CUR_LOW_PT) && (idx <= IDX_VOL_PROP_HI);
    assign pt_sel = 4'(idx - IDX_CUR_LOW_PT);

    // Byte lanes 0 and 1 carry the 16-bit value
    always_comb begin
        wdat = pt_hit ? pt_r[pt_sel] : 16'h0000;
        if (idx == IDX_MAX_FREQ) begin
            wdat = max_freq_r;
        end
        if (sel_i[0]) begin
            wdat[7:0] = dat_i[7:0];
        end
        if (sel_i[1]) begin
            wdat[15:8] = dat_i[15:8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Points and proportions stored verbatim, scaled by 100
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_pt
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pt_r[gi] <= PT_RST[gi];
                end else if (wr_en && pt_hit && pt_sel == 4'(gi)) begin
                    pt_r[gi] <= wdat;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            curve_sel_r  <= TPCM_CURVE_NORMAL;
            input_type_r <= RST_INPUT_TYPE;
            max_freq_r   <= RST_MAX_FREQ;
        end else if (wr_en && sel_i[0]) begin
            if (idx == IDX_CURVE_SEL) begin
                curve_sel_r <= dat_i[1:0];
            end else if (idx == IDX_INPUT_TYPE) begin
                input_type_r <= dat_i[1:0];
            end else if (idx == IDX_MAX_FREQ) begin
                max_freq_r <= wdat;
            end
        end else if (wr_en && sel_i[1] && idx == IDX_MAX_FREQ) begin
            max_freq_r <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            if (pt_hit) begin
                dat_o <= {16'h0000, pt_r[pt_sel]};
            end else if (idx == IDX_CURVE_SEL) begin
                dat_o <= {30'h0000_0000, curve_sel_r};
            end else if (idx == IDX_INPUT_TYPE) begin
                dat_o <= {30'h0000_0000, input_type_r};
            end else if (idx == IDX_MAX_FREQ) begin
                dat_o <= {16'h0000, max_freq_r};
            end else if (idx == IDX_STATUS) begin
                dat_o <= {27'h0000_0000, status_r};
            end else if (idx == IDX_CUR_LEVEL) begin
                dat_o <= {16'h0000, cur_lvl_r};
            end else if (idx == IDX_VOL_LEVEL) begin
                dat_o <= {16'h0000, vol_lvl_r};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Input level capture and range clamp
    // ------------------------------------------------------------------
    logic [15:0] cur_clamped;
    logic [15:0] vol_clamped;

    // Readings outside the selected span are pinned to its ends
    always_comb begin
        cur_clamped = (current_level_i > CUR_MAX_20MA) ? CUR_MAX_20MA
                                                       : current_level_i;
        if (input_type_r == TPCM_IT_CUR_4_20 &&
            cur_clamped < CUR_MIN_4MA) begin
            cur_clamped = CUR_MIN_4MA;
        end
        vol_clamped = (voltage_level_i > VOL_MAX_10V) ? VOL_MAX_10V
                                                      : voltage_level_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_lvl_r <= 16'h0000;
            vol_lvl_r <= 16'h0000;
        end else if (level_valid_i) begin
            cur_lvl_r <= cur_clamped;
            vol_lvl_r <= vol_clamped;
        end
    end

    // ------------------------------------------------------------------
    // Segment selection
    // ------------------------------------------------------------------
    logic        use_cur;
    logic [15:0] lo_pt;
    logic [15:0] mid_pt;
    logic [15:0] hi_pt;
    logic [15:0] lvl;
    logic signed [16:0] p_lo;
    logic signed [16:0] p_mid;
    logic signed [16:0] p_hi;
    logic        below;
    logic [15:0] x0;
    logic [15:0] x1;
    logic signed [16:0] y0;
    logic signed [16:0] y1;
    logic [15:0] dx;
    logic [15:0] span;

    assign use_cur = (curve_sel_r == TPCM_CURVE_CURRENT);
    assign lo_pt   = use_cur ? pt_r[0] : pt_r[6];
    assign mid_pt  = use_cur ? pt_r[2] : pt_r[8];
    assign hi_pt   = use_cur ? pt_r[4] : pt_r[10];
    assign lvl     = use_cur ? cur_lvl_r : vol_lvl_r;
    // Current proportions unsigned, voltage ones signed
    assign p_lo  = use_cur ? $signed({1'b0, pt_r[1]})
                           : $signed({pt_r[7][15], pt_r[7]});
    assign p_mid = use_cur ? $signed({1'b0, pt_r[3]})
                           : $signed({pt_r[9][15], pt_r[9]});
    assign p_hi  = use_cur ? $signed({1'b0, pt_r[5]})
                           : $signed({pt_r[11][15], pt_r[11]});
    // At the low point itself the output is still zero
    assign below = (lvl <= lo_pt);

    // Proportions are taken as given, whatever their order
    always_comb begin
        if (lvl <= mid_pt) begin
            x0 = lo_pt;
            x1 = mid_pt;
            y0 = p_lo;
            y1 = p_mid;
        end else begin
            x0 = mid_pt;
            x1 = hi_pt;
            y0 = p_mid;
            y1 = p_hi;
        end
        // Level beyond the high point holds the high proportion
        dx   = (lvl > x1) ? 16'(x1 - x0) : 16'(lvl - x0);
        span = 16'(x1 - x0);
    end

    // ------------------------------------------------------------------
    // Interpolation
    // ------------------------------------------------------------------
    // Division is combinational to keep latency at one cycle; timing at
    // 40 MHz is the trade-off accepted for a simple pipeline
    logic signed [17:0] dy;
    logic signed [34:0] prod;
    logic signed [34:0] quot;
    logic signed [16:0] pct;
    logic [31:0]        freq_full;
    logic               mapped;
    logic [15:0]        pct_mag;

    assign dy   = 18'(y1) - 18'(y0);
    assign prod = 35'(dy) * $signed({19'h0_0000, dx});
    // Coincident points give a zero span; hold the segment start
    assign quot = (span == 16'h0000) ? 35'sh0_0000_0000
                : prod / $signed({19'h0_0000, span});
    always_comb begin
        if (below) begin
            pct = 17'sh0_0000;
        end else begin
            // Strictly above the low point starts at the low proportion
            pct = 17'(18'(y0) + 18'(quot));
        end
    end

    assign mapped  = (curve_sel_r == TPCM_CURVE_VOLTAGE) || use_cur;
    assign pct_mag = pct[16] ? 16'(-pct) : 16'(pct);
    // Percent of full scale times maximum frequency
    assign freq_full = 32'((48'(pct_mag) * 48'(max_freq_r)) / 48'(PCT_FULL));

    // ------------------------------------------------------------------
    // Command outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_valid_o   <= 1'b0;
            cmd_curve_o   <= 1'b0;
            cmd_percent_o <= 16'h0000;
            cmd_reverse_o <= 1'b0;
            cmd_freq_o    <= 32'h0000_0000;
        end else begin
            cmd_valid_o   <= mapped;
            cmd_curve_o   <= use_cur;
            cmd_percent_o <= mapped ? 16'(pct) : 16'h0000;
            // Negative voltage proportion runs reverse
            cmd_reverse_o <= mapped && pct[16];
            cmd_freq_o    <= mapped ? freq_full : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= 5'h00;
        end else begin
            status_r[ST_CUR_BELOW]  <= (cur_lvl_r <= pt_r[0]);
            status_r[ST_VOL_BELOW]  <= (vol_lvl_r <= pt_r[6]);
            status_r[ST_CUR_ACTIVE] <= use_cur;
            status_r[ST_VOL_ACTIVE] <= (curve_sel_r == TPCM_CURVE_VOLTAGE);
            status_r[ST_REVERSE]    <= mapped && pct[16];
        end
    end

endmodule : tpcm_curve_mapper

// ---- tpcm_curve_mapper_sva.sv ----
`timescale 1ns/1ps
module tpcm_curve_mapper_sva
    import tpcm_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        cmd_valid_o,
    input wire logic        cmd_curve_o,
    input wire logic [15:0] cmd_percent_o,
    input wire logic        cmd_reverse_o,
    input wire logic [31:0] cmd_freq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_pulse;
        ack_o ##1 !ack_o;
    endsequence
    a_req_gets_ack: assert property (s_req |=> s_pulse)
        else $error("request not answered by a single ack");
    a_ack_has_cause: assert property ($rose(ack_o) |->
        $past(cyc_i) && $past(stb_i))
        else $error("ack without a request");
    a_read_hi_zero: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0)
        else $error("read data upper half not zero");

    // ------------------------------------------------------------------
    // Command outputs
    // ------------------------------------------------------------------
    a_idle_zero: assert property (!cmd_valid_o |->
        cmd_percent_o == 16'h0 && cmd_freq_o == 32'h0 && !cmd_reverse_o)
        else $error("normal curve must give a zero command");
    a_curve_needs_valid: assert property (
        cmd_curve_o |-> cmd_valid_o)
        else $error("current curve flag without a valid command");
    a_reverse_sign: assert property (
        cmd_reverse_o == cmd_percent_o[15])
        else $error("direction disagrees with percent sign");
    a_cur_unsigned: assert property (
        cmd_curve_o |-> !cmd_percent_o[15])
        else $error("current curve percent negative");
    a_pct_bound: assert property (
        $signed(cmd_percent_o) <= $signed(PCT_FULL) &&
        $signed(cmd_percent_o) >= -$signed(PCT_FULL))
        else $error("percent beyond full scale");
    a_freq_zero: assert property (
        cmd_percent_o == 16'h0 |-> cmd_freq_o == 32'h0)
        else $error("frequency nonzero at zero percent");
endmodule : tpcm_curve_mapper_sva

bind tpcm_curve_mapper tpcm_curve_mapper_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .cmd_valid_o(cmd_valid_o),
    .cmd_curve_o(cmd_curve_o), .cmd_percent_o(cmd_percent_o),
    .cmd_reverse_o(cmd_reverse_o), .cmd_freq_o(cmd_freq_o));

// ---- test_tpcm_curve_mapper.sv ----
`timescale 1ns/1ps
module test_tpcm_curve_mapper
    import tpcm_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, level_valid_i = 1'b0, probe_r = 1'b0;
    logic [15:0] adr_i = 16'h0, current_level_i = 16'h0;
    logic [15:0] voltage_level_i = 16'h0;
    logic [3:0]  sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, cmd_freq_o, seed = 32'h7C97;
    logic        ack_o, cmd_valid_o, cmd_curve_o, cmd_reverse_o;
    logic [15:0] cmd_percent_o;
    logic [31:0] rd_q[$];
    logic [50:0] cmd_q[$];
    int          num_errors = 0, num_checks = 0;
    logic [15:0] rstv [12] = '{RST_CUR_LOW_PT, RST_CUR_PROP_LO,
        RST_CUR_MID_PT, RST_CUR_PROP_MID, RST_CUR_HIGH_PT, RST_CUR_PROP_HI,
        RST_VOL_LOW_PT, RST_VOL_PROP_LO, RST_VOL_MID_PT, RST_VOL_PROP_MID,
        RST_VOL_HIGH_PT, RST_VOL_PROP_HI};
    int          lim [12] = '{2001, 10001, 2001, 10001, 2001, 10001,
        1001, 10001, 1001, 10001, 1001, 10001};

    tpcm_curve_mapper DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .level_valid_i(level_valid_i), .current_level_i(current_level_i),
        .voltage_level_i(voltage_level_i), .cmd_valid_o(cmd_valid_o),
        .cmd_curve_o(cmd_curve_o), .cmd_percent_o(cmd_percent_o),
        .cmd_reverse_o(cmd_reverse_o), .cmd_freq_o(cmd_freq_o));

    always #12.5 clk_i = ~clk_i;

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Frequency derived from the reset maximum, never rewritten here
    function logic [50:0] exp_cmd(input logic v, input logic c, input int p);
        int a;
        a = (p < 0) ? -p : p;
        return {v, c, p < 0, 16'(p), 32'(a * int'(RST_MAX_FREQ) / 10000)};
    endfunction : exp_cmd

    // ------------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        logic [31:0] er;
        logic [50:0] ec;
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            er = rd_q.pop_front();
            num_checks++;
            if (dat_o !== er) begin
                num_errors++;
                $display("unexpected at %0t: read %h not %h", $time, dat_o, er);
            end
        end
        if (probe_r === 1'b1) begin
            ec = cmd_q.pop_front();
            num_checks++;
            if ({cmd_valid_o, cmd_curve_o, cmd_reverse_o, cmd_percent_o,
                 cmd_freq_o} !== ec) begin
                num_errors++;
                $display("unexpected at %0t: cmd wrong, want %h", $time, ec);
            end
        end
    end

    task tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task wb(input logic w, input logic [11:0] idx, input logic [15:0] d);
        int n;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {2'b00, idx, 2'b00};
        dat_i <= {16'h0000, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (n == 20) begin
            num_errors++;
            $display("unexpected at %0t: no ack", $time);
            tally_and_finish();
        end else
            @(posedge clk_i);
    endtask : wb

    task rd(input logic [11:0] idx, input logic [15:0] e);
        rd_q.push_back({16'h0000, e});
        wb(1'b0, idx, 16'h0000);
    endtask : rd

    // Two edges of pipeline, three more of margin
    task lvl(input logic [15:0] c, v, input logic ev, ec, input int p);
        current_level_i <= c;
        voltage_level_i <= v;
        level_valid_i   <= 1'b1;
        @(posedge clk_i);
        level_valid_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        cmd_q.push_back(exp_cmd(ev, ec, p));
        probe_r <= 1'b1;
        @(posedge clk_i);
        probe_r <= 1'b0;
    endtask : lvl

    task set6(input logic [11:0] b, input logic [15:0] v0, v1, v2, v3, v4, v5);
        logic [15:0] v [6];
        v = '{v0, v1, v2, v3, v4, v5};
        for (int k = 0; k < 6; k++) wb(1'b1, 12'(b + k), v[k]);
    endtask : set6

    initial begin
        logic [31:0] r;
        int          v;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            rd(12'(IDX_CUR_LOW_PT + i), rstv[i]);
        end
        rd(IDX_CURVE_SEL, 16'h0000);
        rd(IDX_INPUT_TYPE, 16'(RST_INPUT_TYPE));
        rd(IDX_MAX_FREQ, RST_MAX_FREQ);
        wb(1'b1, 12'h3FF, 16'hA5A5);
        rd(12'h3FF, 16'h0000);
        $display("test reset_defaults done");
        for (int i = 0; i < 12; i++) begin
            r = xs();
            v = int'(r % lim[i]);
            if (i > 6 && i % 2 == 1 && r[31]) v = -v;
            wb(1'b1, 12'(IDX_CUR_LOW_PT + i), 16'(v));
            rd(12'(IDX_CUR_LOW_PT + i), 16'(v));
        end
        wb(1'b1, IDX_CUR_MID_PT, 16'hBEEF);
        // Low lane only: upper byte must survive
        sel_i <= 4'h1;
        wb(1'b1, IDX_CUR_MID_PT, 16'h1234);
        sel_i <= 4'hF;
        rd(IDX_CUR_MID_PT, 16'hBE34);
        $display("test readback done");
        wb(1'b1, IDX_CURVE_SEL, 16'h0001);
        wb(1'b1, IDX_INPUT_TYPE, 16'h0000);
        set6(IDX_VOL_LOW_PT, 16'h0064, 16'h03E8, 16'h01F4, 16'h1388,
             16'h03E8, 16'hEC78);
        lvl(16'h0000, 16'h0063, 1'b1, 1'b0, 0);
        lvl(16'h0000, 16'h0064, 1'b1, 1'b0, 0);
        lvl(16'h0000, 16'h0065, 1'b1, 1'b0, 1010);
        lvl(16'h0000, 16'h012C, 1'b1, 1'b0, 3000);
        lvl(16'h0000, 16'h02EE, 1'b1, 1'b0, 0);
        lvl(16'h0000, 16'h0384, 1'b1, 1'b0, -3000);
        lvl(16'h0000, 16'h03E8, 1'b1, 1'b0, -5000);
        lvl(16'h0000, 16'h07D0, 1'b1, 1'b0, -5000);
        $display("test voltage_curve done");
        wb(1'b1, IDX_CURVE_SEL, 16'h0002);
        wb(1'b1, IDX_INPUT_TYPE, 16'h0001);
        set6(IDX_CUR_LOW_PT, 16'h00C8, 16'h03E8, 16'h04B0, 16'h2328,
             16'h07D0, 16'h0BB8);
        lvl(16'h00C7, 16'h0000, 1'b1, 1'b1, 0);
        lvl(16'h00C8, 16'h0000, 1'b1, 1'b1, 0);
        lvl(16'h00C9, 16'h0000, 1'b1, 1'b1, 1008);
        lvl(16'h03E8, 16'h0000, 1'b1, 1'b1, 7400);
        lvl(16'h0640, 16'h0000, 1'b1, 1'b1, 6000);
        wb(1'b1, IDX_CUR_PROP_HI, 16'h2710);
        lvl(16'h07D0, 16'h0000, 1'b1, 1'b1, 10000);
        lvl(16'h0FA0, 16'h0000, 1'b1, 1'b1, 10000);
        wb(1'b1, IDX_INPUT_TYPE, 16'h0002);
        lvl(16'h0064, 16'h0000, 1'b1, 1'b1, 2600);
        $display("test current_curve done");
        wb(1'b1, IDX_CURVE_SEL, 16'h0000);
        lvl(16'h03E8, 16'h01F4, 1'b0, 1'b0, 0);
        $display("test normal_curve done");
        tally_and_finish();
    end
endmodule : test_tpcm_curve_mapper
